//--- bdce_bank.sv
// Register bank for balancing recovery delays and scan channel enables, with the delay timer.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps
module bdce_bank (
   // Clock and reset.
   input wire logic CLK_I,
   input wire logic RSTN_I,
   // Avalon-MM slave.
   input wire logic [bdce_pkg::BDCE_ADDR_W-1:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   output logic [1:0] AVS_RESPONSE_O,
   // Balancing context from the sequencer and balancing engine.
   input wire logic [1:0] BAL_MODE_I,
   input wire logic AUTO_BALANCE_SWITCH_DISABLE_I,
   input wire logic ALTERNATE_MUX_SELECT_I,
   input wire logic [1:0] BALANCE_MEASURE_SETTING_I,
   input wire logic PAIR_DONE_I,
   input wire logic ADC_REQ_I,
   input wire logic SCAN_ACTIVE_I,
   input wire logic SCAN_IS_ADC_I,
   // Outputs to the sequencer and analog front end.
   output logic ADC_START_O,
   output logic RECOVERY_BUSY_O,
   output logic [13:0] CELL_CHANNEL_ENABLE_O,
   output logic BLOCK_MEASURE_O,
   output logic BLOCK_DIVIDER_ON_O
);
   import bdce_pkg::*;

   logic [15:0] delays;
   logic [15:0] enables;
   logic ack;
   logic [31:0] rdata;
   logic [BDCE_DLY_W-1:0] steps_left;
   logic [BDCE_STEP_W-1:0] step_cnt;
   logic busy;
   logic divider_on;

   // Address decode and access qualification.
   wire hit_delays = AVS_ADDRESS_I == BDCE_ADDR_DELAYS;
   wire hit_enables = AVS_ADDRESS_I == BDCE_ADDR_ENABLES;
   wire hit_status = AVS_ADDRESS_I == BDCE_ADDR_STATUS;
   wire hit_any = hit_delays | hit_enables | hit_status;
   wire req = (AVS_READ_I | AVS_WRITE_I) & ~ack;
   wire wr = AVS_WRITE_I & ~ack;
   wire [15:0] be_mask = {{8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};

   // Merged write values honour byte enables; enables bit 15 is masked and reads back zero
   wire [15:0] next_delays = (delays & ~be_mask) | (AVS_WRITEDATA_I[15:0] & be_mask);
   wire [15:0] next_enables = ((enables & ~be_mask) | (AVS_WRITEDATA_I[15:0] & be_mask))
      & BDCE_ENABLES_MASK;

   wire [BDCE_DLY_W-1:0] cell_path_delay = delays[BDCE_CELL_DLY_LSB +: BDCE_DLY_W];
   wire [BDCE_DLY_W-1:0] switch_path_delay = delays[BDCE_SW_DLY_LSB +: BDCE_DLY_W];
   wire block_voltage_enable = enables[BDCE_BLOCK_EN_BIT];

   wire manual_use = (BAL_MODE_I == BDCE_BAL_MANUAL) & AUTO_BALANCE_SWITCH_DISABLE_I;
   wire auto_use = (BAL_MODE_I == BDCE_BAL_AUTO) & BALANCE_MEASURE_SETTING_I[1] & PAIR_DONE_I;
   wire [BDCE_DLY_W-1:0] sel_delay = ALTERNATE_MUX_SELECT_I ? switch_path_delay
      : cell_path_delay;
   wire trigger = ADC_REQ_I & ~busy & (manual_use | auto_use);
   wire step_end = step_cnt == BDCE_STEP_W'(BDCE_STEP_CYC - 1);

   // Read mux; unmapped addresses read zero.
   assign rdata = hit_delays ? {16'h0000, delays}
      : hit_enables ? {16'h0000, enables}
      : hit_status ? {23'h000000, busy, steps_left}
      : 32'h00000000;

   // Bus handshake: one wait cycle, then the acknowledge edge.
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         ack <= 1'b0;
         AVS_READDATA_O <= 32'h00000000;
         AVS_RESPONSE_O <= 2'b00;
      end else begin
         ack <= req;
         if (req) begin
            AVS_READDATA_O <= rdata;
            AVS_RESPONSE_O <= hit_any ? 2'b00 : 2'b11;
         end
      end
   end

   assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack;

   // Register writes; zero reset
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         delays <= BDCE_DELAYS_RST;
         enables <= BDCE_ENABLES_RST;
      end else if (wr) begin
         if (hit_delays) begin
            delays <= next_delays;
         end
         if (hit_enables) begin
            enables <= next_enables;
         end
      end
   end

   // step counting of 96 us units; zero means no wait.
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         busy <= 1'b0;
         steps_left <= '0;
         step_cnt <= '0;
      end else if (trigger) begin
         busy <= sel_delay != '0;
         steps_left <= sel_delay;
         step_cnt <= '0;
      end else if (busy) begin
         step_cnt <= step_end ? '0 : step_cnt + 1'b1;
         if (step_end) begin
            steps_left <= steps_left - 1'b1;
            busy <= steps_left != 8'h01;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         ADC_START_O <= 1'b0;
      end else begin
         ADC_START_O <= (ADC_REQ_I & ~busy & ~trigger)
            | (trigger & (sel_delay == '0))
            | (busy & step_end & (steps_left == 8'h01));
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         divider_on <= 1'b0;
      end else begin
         divider_on <= SCAN_ACTIVE_I & SCAN_IS_ADC_I & block_voltage_enable;
      end
   end

   assign CELL_CHANNEL_ENABLE_O = enables[BDCE_CELL_EN_W-1:0];
   assign BLOCK_MEASURE_O = block_voltage_enable & SCAN_IS_ADC_I;
   assign BLOCK_DIVIDER_ON_O = divider_on;
   assign RECOVERY_BUSY_O = busy;
endmodule

//--- bdce_pkg.sv
// Package with register map, field layout, reset values and timing for the delay/enable bank.
package bdce_pkg;
   // Register indices as printed; byte address is four times the index.
   localparam logic [7:0] BDCE_IDX_DELAYS = 8'h63;
   localparam logic [7:0] BDCE_IDX_ENABLES = 8'h64;
   localparam int BDCE_ADDR_W = 10;
   localparam logic [BDCE_ADDR_W-1:0] BDCE_ADDR_DELAYS = {BDCE_IDX_DELAYS, 2'b00};
   localparam logic [BDCE_ADDR_W-1:0] BDCE_ADDR_ENABLES = {BDCE_IDX_ENABLES, 2'b00};
   // Status register of the recovery timer, an offset chosen for this block.
   localparam logic [BDCE_ADDR_W-1:0] BDCE_ADDR_STATUS = 10'h1a0;
   // Field positions.
   localparam int BDCE_CELL_DLY_LSB = 8;
   localparam int BDCE_SW_DLY_LSB = 0;
   localparam int BDCE_DLY_W = 8;
   localparam int BDCE_BLOCK_EN_BIT = 14;
   localparam int BDCE_CELL_EN_W = 14;
   // Reset values.
   localparam logic [15:0] BDCE_DELAYS_RST = 16'h0000;
   localparam logic [15:0] BDCE_ENABLES_RST = 16'h0000;
   localparam logic [15:0] BDCE_ENABLES_MASK = 16'h7fff;
   // Timing: 96 us per delay step at a 25 MHz clock.
   localparam int BDCE_CLK_HZ = 25000000;
   localparam int BDCE_STEP_NS = 96000;
   localparam int BDCE_STEP_CYC = (BDCE_STEP_NS / 1000) * (BDCE_CLK_HZ / 1000000);
   localparam int BDCE_STEP_W = 12;
   // Balancing mode of the balancing engine.
   typedef enum logic [1:0] {
      BDCE_BAL_OFF,
      BDCE_BAL_MANUAL,
      BDCE_BAL_AUTO
   } bdce_bal_mode_t;
endpackage

//--- bdce_bank_props.sv
// Checker of the bus handshake, conversion start and block voltage outputs.
`timescale 1ns/10ps
module bdce_props (
   // Watched ports.
   input wire logic CLK_I, RSTN_I, AVS_READ_I, AVS_WRITE_I, AVS_WAITREQUEST_O,
   input wire logic [bdce_pkg::BDCE_ADDR_W-1:0] AVS_ADDRESS_I,
   input wire logic [1:0] AVS_RESPONSE_O,
   input wire logic ADC_REQ_I, ADC_START_O, RECOVERY_BUSY_O, SCAN_ACTIVE_I,
   input wire logic SCAN_IS_ADC_I, BLOCK_MEASURE_O, BLOCK_DIVIDER_ON_O
);
   import bdce_pkg::*;
   // Pending request and unmapped address decode.
   wire req = AVS_READ_I || AVS_WRITE_I;
   wire unm = !(AVS_ADDRESS_I inside {BDCE_ADDR_DELAYS, BDCE_ADDR_ENABLES, BDCE_ADDR_STATUS});
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);
   property p_wait1; req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O; endproperty
   a_wait1: assert property (p_wait1) else $error("no ack after one wait");
   property p_resp; req && AVS_WAITREQUEST_O |=> AVS_RESPONSE_O == {2{$past(unm)}}; endproperty
   a_resp: assert property (p_resp) else $error("bad response");
   property p_adcb; !SCAN_IS_ADC_I |-> !BLOCK_MEASURE_O; endproperty
   a_adcb: assert property (p_adcb) else $error("block in comparator scan");
   property p_divoff; !SCAN_ACTIVE_I |=> !BLOCK_DIVIDER_ON_O; endproperty
   a_divoff: assert property (p_divoff) else $error("divider left on");
   property p_divon; SCAN_ACTIVE_I && BLOCK_MEASURE_O |=> BLOCK_DIVIDER_ON_O; endproperty
   a_divon: assert property (p_divon) else $error("divider not on");
   property p_start; ADC_START_O |=> !ADC_START_O; endproperty
   a_start: assert property (p_start) else $error("start not a pulse");
   property p_req;
      ADC_REQ_I && !RECOVERY_BUSY_O |-> ##[1:2] (ADC_START_O || RECOVERY_BUSY_O);
   endproperty
   a_req: assert property (p_req) else $error("request dropped");
   property p_busy; $rose(RECOVERY_BUSY_O) |-> RECOVERY_BUSY_O [*8]; endproperty
   a_busy: assert property (p_busy) else $error("wait too short");
endmodule
bind bdce_bank bdce_props chk (.*);

//--- balance_delay_channel_enable_test.sv
// Self-checking bench of the delay and channel enable bank.
`timescale 1ns/10ps
module balance_delay_channel_enable_test;
   import bdce_pkg::*;
   logic CLK_I = '0, RSTN_I = '0, AVS_READ_I = '0, AVS_WRITE_I = '0, ADC_REQ_I = '0;
   logic AUTO_BALANCE_SWITCH_DISABLE_I = '0, ALTERNATE_MUX_SELECT_I = '0, PAIR_DONE_I = '0;
   logic SCAN_ACTIVE_I = '0, SCAN_IS_ADC_I = '0, AVS_WAITREQUEST_O, ADC_START_O;
   logic RECOVERY_BUSY_O, BLOCK_MEASURE_O, BLOCK_DIVIDER_ON_O;
   logic [1:0] BAL_MODE_I = '0, BALANCE_MEASURE_SETTING_I = '0, AVS_RESPONSE_O;
   logic [9:0] AVS_ADDRESS_I = '0;
   logic [31:0] AVS_WRITEDATA_I = '0, AVS_READDATA_O;
   logic [3:0] AVS_BYTEENABLE_I = 4'hf;
   logic [13:0] CELL_CHANNEL_ENABLE_O;
   int fails = 0, num_checks = 0, n;
   bdce_bank uut (.*);
   // Clock of 40 ns period.
   always #20 CLK_I = !CLK_I;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (e !== s) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Bus access held until waitrequest is sampled low; a read is compared with d.
   task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
      int i = 0;
      AVS_ADDRESS_I <= a;
      AVS_WRITEDATA_I <= d;
      AVS_WRITE_I <= w;
      AVS_READ_I <= !w;
      // The request is on the bus from this edge; waitrequest is judged at each later edge.
      @(posedge CLK_I);
      while (AVS_WAITREQUEST_O !== 1'b0 && i < 9) begin
         i++;
         @(posedge CLK_I);
      end
      if (!w) chk("readdata", d, AVS_READDATA_O);
      AVS_WRITE_I <= 1'b0;
      AVS_READ_I <= 1'b0;
      @(posedge CLK_I);
      chk("ack", 0, i == 9);
      if (i == 9) results();
   endtask
   // Conversion request; counts edges until the start pulse is seen.
   task automatic dly(input logic [1:0] m, input logic s, x, p, input int e);
      logic b = 1'b0;
      BAL_MODE_I <= m;
      AUTO_BALANCE_SWITCH_DISABLE_I <= s;
      ALTERNATE_MUX_SELECT_I <= x;
      PAIR_DONE_I <= p;
      BALANCE_MEASURE_SETTING_I <= {p, 1'b0};
      ADC_REQ_I <= 1'b1;
      @(posedge CLK_I);
      ADC_REQ_I <= 1'b0;
      for (n = 1; n < 9000 && ADC_START_O !== 1'b1; n++) begin
         @(posedge CLK_I);
         if (RECOVERY_BUSY_O === 1'b1) b = 1'b1;
      end
      chk("start delay", e, (n >= e && n <= e + 3) ? e : n);
      chk("busy seen", e > 1, b);
      if (n == 9000) results();
   endtask
   // Reset values, readback, delay selection and block voltage scan.
   initial begin
      repeat (2) @(posedge CLK_I);
      RSTN_I <= 1'b1;
      @(posedge CLK_I);
      acc(0, BDCE_ADDR_DELAYS, 0);
      acc(0, BDCE_ADDR_ENABLES, 0);
      acc(1, BDCE_ADDR_DELAYS, 32'h0102);
      acc(1, BDCE_ADDR_ENABLES, 32'hffff);
      acc(0, BDCE_ADDR_DELAYS, 32'h0102);
      acc(0, BDCE_ADDR_ENABLES, 32'h7fff);
      acc(0, 10'h3fc, 0);
      chk("response", 2'h3, AVS_RESPONSE_O);
      chk("cell enables", 14'h3fff, CELL_CHANNEL_ENABLE_O);
      dly(1, 1, 0, 0, 2400);
      dly(1, 1, 1, 0, 4800);
      dly(2, 0, 0, 1, 2400);
      dly(2, 0, 1, 1, 4800);
      dly(2, 0, 0, 0, 1);
      dly(1, 0, 0, 0, 1);
      acc(1, BDCE_ADDR_DELAYS, 32'h0002);
      dly(1, 1, 0, 0, 1);
      SCAN_ACTIVE_I <= 1'b1;
      SCAN_IS_ADC_I <= 1'b1;
      ALTERNATE_MUX_SELECT_I <= 1'b1;
      repeat (2) @(posedge CLK_I);
      chk("block measure", 1, BLOCK_MEASURE_O);
      chk("divider", 1, BLOCK_DIVIDER_ON_O);
      SCAN_IS_ADC_I <= 1'b0;
      repeat (2) @(posedge CLK_I);
      chk("block measure", 0, BLOCK_MEASURE_O);
      chk("divider", 0, BLOCK_DIVIDER_ON_O);
      SCAN_ACTIVE_I <= 1'b0;
      // A second reset in mid-run must clear both registers again.
      RSTN_I <= 1'b0;
      repeat (2) @(posedge CLK_I);
      RSTN_I <= 1'b1;
      @(posedge CLK_I);
      acc(0, BDCE_ADDR_ENABLES, 0);
      acc(0, BDCE_ADDR_DELAYS, 0);
      results();
   end
endmodule
